// ==== rtl/timer_pkg.sv ====
// Shared constants for the periodic interval timer
package timer_pkg;
   localparam int DATA_W  = 32;
   localparam int IDX_W   = 4;
   localparam int COUNT_W = 24;

   // Register indices; byte address is four times the index
   localparam logic [IDX_W-1:0] IDX_COUNT  = 4'h8;
   localparam logic [IDX_W-1:0] IDX_RELOAD = 4'h9;
   localparam logic [IDX_W-1:0] IDX_STATUS = 4'ha;
   localparam logic [IDX_W-1:0] IDX_MASK   = 4'hb;
   localparam logic [IDX_W-1:0] IDX_CTRL   = 4'hc;
   localparam logic [IDX_W-1:0] IDX_NONE   = 4'hf;

   // Reload register flag and enable fields
   localparam int OVERRUN_BIT = 26;
   localparam int EXPIRY_BIT  = 25;
   localparam int ENABLE_BIT  = 24;

   // Interrupt status, mask and control fields
   localparam int EV_W        = 2;
   localparam int EV_EXPIRY   = 0;
   localparam int EV_OVERRUN  = 1;
   localparam int CTRL_BLOCK   = 0;
   localparam int CTRL_DISABLE = 1;

   // Reset values
   localparam logic [COUNT_W-1:0] COUNT_RESET  = 24'hffffff;
   localparam logic [COUNT_W-1:0] RELOAD_RESET = 24'h000000;
   localparam logic [EV_W-1:0]    EV_RESET     = 2'h0;
   localparam logic [EV_W-1:0]    CTRL_RESET   = 2'h0;

   typedef enum logic [2:0] {
      S_IDLE  = 3'b001,
      S_WRITE = 3'b010,
      S_READ  = 3'b100
   } bus_state_t;
endpackage

// ==== rtl/reg_access_if.sv ====
// Register access carrier between bus slave and timer registers
`timescale 1ns/10ps
interface reg_access_if;
   import timer_pkg::*;
   logic              wr;
   logic [IDX_W-1:0]  addr;
   logic [DATA_W-1:0] wdata;
   logic [DATA_W-1:0] rdata;
   logic              priv;
   modport bus  (output wr, addr, wdata, priv, input rdata);
   modport regs (input wr, addr, wdata, priv, output rdata);
endinterface

// ==== rtl/ahb_reg_slave.sv ====
// AHB-Lite slave front end: zero-wait writes, one-wait reads
`timescale 1ns/10ps
module ahb_reg_slave (
   input  wire logic                      clock,
   input  wire logic                      reset_n,
   input  wire logic                      clockEnable,
   input  wire logic                      hsel,
   input  wire logic [timer_pkg::DATA_W-1:0] haddr,
   input  wire logic [1:0]                htrans,
   input  wire logic                      hwrite,
   input  wire logic [3:0]                hprot,
   input  wire logic                      hready,
   input  wire logic [timer_pkg::DATA_W-1:0] hwdata,
   output logic      [timer_pkg::DATA_W-1:0] hrdata,
   output logic                           hreadyout,
   output logic                           hresp,
   reg_access_if.bus                      regs
);
   import timer_pkg::*;

   bus_state_t       state;
   bus_state_t       next_state;
   logic [IDX_W-1:0] addrIdx;
   logic             privReg;
   wire              accept = hsel & htrans[1] & hready;
   wire              inRange = ~|haddr[DATA_W-1:6];
   wire [IDX_W-1:0]  next_addr = inRange ? haddr[5:2] : IDX_NONE;

   always_comb begin
      case (state)
         S_READ:  next_state = S_IDLE;
         S_IDLE, S_WRITE: begin
            if (accept) begin
               next_state = hwrite ? S_WRITE : S_READ;
            end else begin
               next_state = S_IDLE;
            end
         end
         default: next_state = S_IDLE;
      endcase
   end

   assign regs.wr    = (state == S_WRITE) & clockEnable;
   assign regs.addr  = addrIdx;
   assign regs.wdata = hwdata;
   assign regs.priv  = privReg;

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         state     <= S_IDLE;
         addrIdx   <= IDX_NONE;
         privReg   <= 1'b0;
         hrdata    <= '0;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else if (clockEnable) begin
         state     <= next_state;
         hreadyout <= (next_state != S_READ);
         if (accept && state != S_READ) begin
            addrIdx <= next_addr;
            privReg <= hprot[1];
         end
         if (state == S_READ) begin
            hrdata <= regs.rdata;
         end
      end
   end
endmodule

// ==== rtl/interval_counter.sv ====
// Down-counter with reload, expiry and overrun flags
`timescale 1ns/10ps
module interval_counter (
   input  wire logic                        clock,
   input  wire logic                        reset_n,
   input  wire logic                        clockEnable,
   input  wire logic                        writeCount,
   input  wire logic                        writeReload,
   input  wire logic [timer_pkg::DATA_W-1:0] wdata,
   output logic      [timer_pkg::COUNT_W-1:0] count,
   output logic      [timer_pkg::COUNT_W-1:0] reload,
   output logic                             irqEnable,
   output logic                             expiryFlag,
   output logic                             overrunFlag,
   output logic                             expiryEvent,
   output logic                             overrunEvent
);
   import timer_pkg::*;

   wire               atZero = ~|count;
   wire [COUNT_W-1:0] decCount = count - 24'h000001;
   wire [COUNT_W-1:0] next_count;
   wire [COUNT_W-1:0] next_reload;
   wire               next_enable;
   wire               next_expiry;
   wire               next_overrun;
   wire               clrExpiry = writeReload & ~wdata[EXPIRY_BIT];
   wire               clrOverrun = writeReload & ~wdata[OVERRUN_BIT];

   assign expiryEvent  = clockEnable & atZero;                      // [R2] [R3]
   assign overrunEvent = expiryEvent & expiryFlag;                  // [R5]
   assign next_count   = writeCount ? wdata[COUNT_W-1:0] :          // [R17]
                         atZero ? reload : decCount;                // [R1] [R2]
   assign next_reload  = writeReload ? wdata[COUNT_W-1:0] : reload;
   assign next_enable  = writeReload ? wdata[ENABLE_BIT] : irqEnable;
   assign next_expiry  = (expiryFlag & ~clrExpiry) | expiryEvent;   // [R6] [R7]
   assign next_overrun = (overrunFlag & ~clrOverrun) | overrunEvent; // [R5]

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         count       <= COUNT_RESET;
         reload      <= RELOAD_RESET;
         irqEnable   <= 1'b0;
         expiryFlag  <= 1'b0;
         overrunFlag <= 1'b0;
      end else if (clockEnable) begin
         count       <= next_count;
         reload      <= next_reload;
         irqEnable   <= next_enable;
         expiryFlag  <= next_expiry;
         overrunFlag <= next_overrun;
      end
   end
endmodule

// ==== rtl/periodic_interval_timer.sv ====
// Periodic interval timer top: bus slave, counter, interrupts
//
// Functional notes
// [R1] The 24-bit count value drops by one every clock, independent of software.
// [R2] After reaching zero the count reloads next cycle and the expiry flag sets.
// [R3] Count stays zero one full cycle; loaded N expires in cycle N+1.
// [R4] Timer interrupt requested while expiry flag and enable bit are both one.
// [R5] Expiry while expiry flag already set also sets overrun flag, bit 26.
// [R6] Expiry flag, bit 25, sets on every expiry regardless of enable.
// [R7] Expiry flag stays set until software clears it through the reload register.
// [R8] Timer interrupt block bit suppresses timer interrupts like clearing enable.
// [R9] Global interrupt disable bit also suppresses the timer interrupt.
// [R10] Counter register: count value in bits 23-0, bits 31-24 read zero.
// [R11] Reload register: reload value low, overrun/expiry/enable in bits 26/25/24.
// [R12] Both timer registers answer only privileged accesses.
// [R13] Counter register is index 8, reload register is index 9.
// [R14] Software loads first interval, then reload with flags cleared, while disabled.
// [R15] Handler reads reload, clears expiry, writes back, then checks overrun copy.
// [R16] Software disables via the block bit, not read-modify-write of reload.
// [R17] Writing the counter replaces the count; decrement continues from it.
//
// The AHB-Lite register port was left to the implementer.
`timescale 1ns/10ps
module periodic_interval_timer (
   input  wire logic                         clock,
   input  wire logic                         reset_n,
   input  wire logic                         clockEnable,
   input  wire logic                         hsel,
   input  wire logic [timer_pkg::DATA_W-1:0] haddr,
   input  wire logic [1:0]                   htrans,
   input  wire logic                         hwrite,
   input  wire logic [3:0]                   hprot,
   input  wire logic                         hready,
   input  wire logic [timer_pkg::DATA_W-1:0] hwdata,
   output logic      [timer_pkg::DATA_W-1:0] hrdata,
   output logic                              hreadyout,
   output logic                              hresp,
   output logic                              timerIrq,
   output logic                              irq
);
   import timer_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Declarations

   reg_access_if regs ();

   logic [COUNT_W-1:0] count;
   logic [COUNT_W-1:0] reload;
   logic               irqEnable;
   logic               expiryFlag;
   logic               overrunFlag;
   logic               expiryEvent;
   logic               overrunEvent;
   logic [EV_W-1:0]    irqStatus;
   logic [EV_W-1:0]    irqMask;
   logic [EV_W-1:0]    ctrl;

   ////////////////////////////////////////////////////////////////////////////
   // Bus slave

   ahb_reg_slave busSlave (
      .clock       (clock),
      .reset_n     (reset_n),
      .clockEnable (clockEnable),
      .hsel        (hsel),
      .haddr       (haddr),
      .htrans      (htrans),
      .hwrite      (hwrite),
      .hprot       (hprot),
      .hready      (hready),
      .hwdata      (hwdata),
      .hrdata      (hrdata),
      .hreadyout   (hreadyout),
      .hresp       (hresp),
      .regs        (regs.bus)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Address decode

   wire hitCount  = (regs.addr == IDX_COUNT);                       // [R13]
   wire hitReload = (regs.addr == IDX_RELOAD);                      // [R13]
   wire hitStatus = (regs.addr == IDX_STATUS);
   wire hitMask   = (regs.addr == IDX_MASK);
   wire hitCtrl   = (regs.addr == IDX_CTRL);
   wire privWr    = regs.wr & regs.priv;                            // [R12]

   wire writeCount  = privWr & hitCount;                            // [R17]
   wire writeReload = privWr & hitReload;                           // [R7]
   wire writeStatus = privWr & hitStatus;
   wire writeMask   = privWr & hitMask;
   wire writeCtrl   = privWr & hitCtrl;

   ////////////////////////////////////////////////////////////////////////////
   // Read data

   wire [DATA_W-1:0] countWord  = {8'h00, count};                   // [R10]
   wire [DATA_W-1:0] reloadWord = {5'h00, overrunFlag, expiryFlag,
                                   irqEnable, reload};              // [R11]
   wire [DATA_W-1:0] statusWord = {30'h00000000, irqStatus};
   wire [DATA_W-1:0] maskWord   = {30'h00000000, irqMask};
   wire [DATA_W-1:0] ctrlWord   = {30'h00000000, ctrl};

   wire [DATA_W-1:0] selWord = hitCount  ? countWord  :
                               hitReload ? reloadWord :
                               hitStatus ? statusWord :
                               hitMask   ? maskWord   :
                               hitCtrl   ? ctrlWord   : 32'h00000000;

   assign regs.rdata = regs.priv ? selWord : 32'h00000000;         // [R12]

   ////////////////////////////////////////////////////////////////////////////
   // Counter core

   interval_counter counter (
      .clock        (clock),
      .reset_n      (reset_n),
      .clockEnable  (clockEnable),
      .writeCount   (writeCount),
      .writeReload  (writeReload),
      .wdata        (regs.wdata),
      .count        (count),
      .reload       (reload),
      .irqEnable    (irqEnable),
      .expiryFlag   (expiryFlag),
      .overrunFlag  (overrunFlag),
      .expiryEvent  (expiryEvent),
      .overrunEvent (overrunEvent)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt status, mask and control

   wire timerBlock    = ctrl[CTRL_BLOCK];
   wire globalDisable = ctrl[CTRL_DISABLE];

   wire [EV_W-1:0] events    = {overrunEvent, expiryEvent};
   wire [EV_W-1:0] clearBits = writeStatus ? regs.wdata[EV_W-1:0] : EV_RESET;
   wire [EV_W-1:0] next_status = (irqStatus & ~clearBits) | events;
   wire [EV_W-1:0] next_mask   = writeMask ? regs.wdata[EV_W-1:0] : irqMask;
   wire [EV_W-1:0] next_ctrl   = writeCtrl ? regs.wdata[EV_W-1:0] : ctrl;

   wire next_timerIrq = expiryFlag & irqEnable                      // [R4]
                      & ~timerBlock                                 // [R8]
                      & ~globalDisable;                             // [R9]
   wire next_irq      = |(irqStatus & irqMask);

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         irqStatus <= EV_RESET;
         irqMask   <= EV_RESET;
         ctrl      <= CTRL_RESET;
         timerIrq  <= 1'b0;
         irq       <= 1'b0;
      end else if (clockEnable) begin
         irqStatus <= next_status;
         irqMask   <= next_mask;
         ctrl      <= next_ctrl;
         timerIrq  <= next_timerIrq;                                // [R4]
         irq       <= next_irq;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Assertions

   default clocking cb @(posedge clock); endclocking
   default disable iff (!reset_n);

   chk_count_decrement: assert property ( // [R1]
      clockEnable && count != 24'h000000 && !writeCount
      |=> count == $past(count) - 24'h000001
   ) else $error("count did not drop by one");

   chk_reload_on_zero: assert property ( // [R2]
      clockEnable && count == 24'h000000 && !writeCount
      |=> count == $past(reload) && expiryFlag
   ) else $error("zero count did not reload and set expiry");

   chk_zero_based: assert property ( // [R3]
      $rose(expiryFlag) |-> $past(count) == 24'h000000 && $past(clockEnable)
   ) else $error("expiry flag set without a zero cycle");

   sequence sDownToZero;
      clockEnable && count == 24'h000002 && !writeCount
      ##1 clockEnable && !writeCount
      ##1 clockEnable && !writeCount;
   endsequence

   chk_interval_span: assert property ( // [R3]
      sDownToZero |=> expiryFlag && count == $past(reload)
   ) else $error("expiry not in cycle N+1");

   chk_timer_irq: assert property ( // [R4]
      clockEnable && expiryFlag && irqEnable && !timerBlock && !globalDisable
      |=> timerIrq
   ) else $error("timer interrupt missing");

   chk_overrun_set: assert property ( // [R5]
      clockEnable && count == 24'h000000 && expiryFlag |=> overrunFlag
   ) else $error("overrun flag not set on second expiry");

   chk_expiry_any_enable: assert property ( // [R6]
      clockEnable && count == 24'h000000 && !irqEnable |=> expiryFlag
   ) else $error("expiry flag not set with enable off");

   chk_expiry_sticky: assert property ( // [R7]
      expiryFlag && !writeReload |=> expiryFlag
   ) else $error("expiry flag dropped without software write");

   chk_block_masks: assert property ( // [R8]
      clockEnable && timerBlock |=> !timerIrq
   ) else $error("timer interrupt not blocked");

   chk_disable_masks: assert property ( // [R9]
      clockEnable && globalDisable |=> !timerIrq
   ) else $error("timer interrupt not disabled");

   chk_unpriv_write: assert property ( // [R12]
      regs.wr && !regs.priv && hitCount |=> count == $past(count) - 24'h000001
                                        || $past(count) == 24'h000000
   ) else $error("unprivileged write changed the count");

   chk_count_write: assert property ( // [R17]
      clockEnable && writeCount |=> count == $past(regs.wdata[COUNT_W-1:0])
   ) else $error("count write not applied");

   chk_freeze_state: assert property (
      !clockEnable |=> $stable(count) && $stable(expiryFlag) && $stable(irq)
   ) else $error("state moved while clock enable low");

   chk_irq_output: assert property (
      clockEnable && |(irqStatus & irqMask) |=> irq
   ) else $error("interrupt output not raised");

   chk_status_sticky: assert property (
      clockEnable && expiryEvent |=> irqStatus[EV_EXPIRY]
   ) else $error("expiry status bit not set");

   chk_timer_irq_quiet: assert property ( // [R4]
      clockEnable && !(expiryFlag && irqEnable) |=> !timerIrq
   ) else $error("timer interrupt without enabled expiry");

   chk_overrun_cause: assert property ( // [R5]
      $rose(overrunFlag) |-> $past(expiryFlag) && $past(clockEnable)
   ) else $error("overrun flag set without pending expiry");

   chk_overrun_clear: assert property ( // [R5]
      writeReload && !regs.wdata[OVERRUN_BIT] && !overrunEvent |=> !overrunFlag
   ) else $error("overrun flag not cleared by reload write");

   chk_expiry_clear: assert property ( // [R7]
      writeReload && !regs.wdata[EXPIRY_BIT] && !expiryEvent |=> !expiryFlag
   ) else $error("expiry flag not cleared by reload write");

   chk_count_layout: assert property ( // [R10]
      regs.priv && hitCount
      |-> regs.rdata[DATA_W-1:COUNT_W] == 8'h00 && regs.rdata[COUNT_W-1:0] == count
   ) else $error("counter register read layout wrong");

   chk_reload_layout: assert property ( // [R11]
      regs.priv && hitReload
      |-> regs.rdata[DATA_W-1:OVERRUN_BIT+1] == 5'h00 && regs.rdata[COUNT_W-1:0] == reload
          && regs.rdata[OVERRUN_BIT] == overrunFlag && regs.rdata[EXPIRY_BIT] == expiryFlag
          && regs.rdata[ENABLE_BIT] == irqEnable
   ) else $error("reload register read layout wrong");

   chk_reload_write: assert property ( // [R11]
      writeReload |=> reload == $past(regs.wdata[COUNT_W-1:0])
                      && irqEnable == $past(regs.wdata[ENABLE_BIT])
   ) else $error("reload register write not applied");

   chk_unpriv_read: assert property ( // [R12]
      !regs.priv |-> regs.rdata == 32'h00000000
   ) else $error("unprivileged read returned data");

   chk_status_clear: assert property (
      writeStatus && regs.wdata[EV_EXPIRY] && !expiryEvent |=> !irqStatus[EV_EXPIRY]
   ) else $error("expiry status bit not cleared");

   chk_mask_write: assert property (
      writeMask |=> irqMask == $past(regs.wdata[EV_W-1:0])
   ) else $error("mask write not applied");

   chk_ctrl_write: assert property ( // [R8] [R9]
      writeCtrl |=> ctrl == $past(regs.wdata[EV_W-1:0])
   ) else $error("control write not applied");

   chk_irq_quiet: assert property (
      clockEnable && !(|(irqStatus & irqMask)) |=> !irq
   ) else $error("interrupt output raised without cause");

   chk_okay_response: assert property (
      !hresp
   ) else $error("slave response not OKAY");

   chk_read_wait: assert property (
      clockEnable && !hreadyout |=> hreadyout
   ) else $error("read wait longer than one cycle");

   cov_expiry:    cover property (clockEnable && expiryEvent);
   cov_overrun:   cover property (clockEnable && overrunEvent);
   cov_timer_irq: cover property ($rose(timerIrq));
   cov_count_wr:  cover property (writeCount ##1 clockEnable ##1 clockEnable);
   cov_freeze:    cover property (!clockEnable ##1 clockEnable);
endmodule

// ==== test/tb_top.sv ====
// Self-checking testbench for the periodic interval timer
`timescale 1ns/10ps
module tb_top;
   import timer_pkg::*;
   typedef struct {logic kind; logic [31:0] exp; logic [31:0] mask;} note_t;
   logic        clock;
   logic        reset_n;
   logic        clockEnable;
   logic        hsel;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [3:0]  hprot;
   logic        hready;
   logic [31:0] hwdata;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        timerIrq;
   logic        irq;
   logic [31:0] rnd;
   logic [31:0] q;
   logic [31:0] v;
   int          cyc;
   int          lastEdge;
   int          e0;
   int          nErrors;
   int          checked;
   note_t       expQ[$];
   logic [31:0] gotQ[$];
   note_t       nt;
   logic [31:0] gv;
   localparam logic [31:0] A_COUNT  = {26'h0, IDX_COUNT, 2'b00};
   localparam logic [31:0] A_RELOAD = {26'h0, IDX_RELOAD, 2'b00};
   localparam logic [31:0] A_STATUS = {26'h0, IDX_STATUS, 2'b00};
   localparam logic [31:0] A_MASK   = {26'h0, IDX_MASK, 2'b00};
   localparam logic [31:0] A_CTRL   = {26'h0, IDX_CTRL, 2'b00};
   localparam logic [31:0] ALL      = 32'hffffffff;
   assign hready = hreadyout;
   periodic_interval_timer u_periodic_interval_timer (.clock(clock), .reset_n(reset_n),
      .clockEnable(clockEnable), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hprot(hprot), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(), .timerIrq(timerIrq), .irq(irq));
   ////////////////////////////////////////////////////////////////////////////////
   initial clock = 1'b0;
   always #2.5 clock = ~clock;
   always @(posedge clock) cyc <= cyc + 1;
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h0);
   endfunction
   task reportAndStop;
      $display("compares %0d errors %0d", checked, nErrors);
      if (nErrors == 0 && checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d, input logic p);
      int k;
      @(posedge clock);
      rnd = lfsr(rnd);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= w;
      haddr <= a;
      hprot <= {2'b00, p, 1'b1};
      k = 0;
      do begin @(posedge clock); k++; end while (hready !== 1'b1 && k < 20);
      htrans <= 2'b00;
      hsel <= 1'b0;
      hwdata <= w ? d : rnd;
      do begin @(posedge clock); k++; end while (hready !== 1'b1 && k < 40);
      q = hrdata;
      lastEdge = cyc + 1;
      if (hready !== 1'b1) begin
         nErrors++;
         $display("ERROR %0t bus wait ran out", $time);
         reportAndStop();
      end
   endtask
   task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic p = 1'b1);
      bus(1'b1, a, d, p);
   endtask
   task automatic rd(input logic [31:0] a, input logic [31:0] e, input logic [31:0] m,
                     input logic p = 1'b1);
      bus(1'b0, a, 32'h0, p);
      expQ.push_back(note_t'{1'b0, e, m});
      gotQ.push_back(q);
   endtask
   task automatic level_at(input int t, input logic sel, input logic e);
      int g;
      #1;
      g = 0;
      while (cyc < t && g < 5000) begin @(posedge clock); #1; g++; end
      if (cyc != t) begin
         nErrors++;
         $display("ERROR %0t level check missed cycle %0d", $time, t);
      end
      expQ.push_back(note_t'{1'b1, {31'h0, e}, 32'h1});
      gotQ.push_back({31'h0, sel ? irq : timerIrq});
   endtask
   task automatic done(input string name);
      $display("test %s done at %0t", name, $time);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic compare_word(input logic [31:0] g, input logic [31:0] e, input logic [31:0] m);
      checked++;
      if ((g & m) !== (e & m)) begin
         nErrors++;
         $display("ERROR %0t read %h expected %h mask %h", $time, g, e, m);
      end
   endtask
   task automatic compare_level(input logic g, input logic e);
      checked++;
      if (g !== e) begin
         nErrors++;
         $display("ERROR %0t level %b expected %b", $time, g, e);
      end
   endtask
   always begin
      wait (gotQ.size() != 0);
      nt = expQ.pop_front();
      gv = gotQ.pop_front();
      if (nt.kind)
         compare_level(gv[0], nt.exp[0]);
      else
         compare_word(gv, nt.exp, nt.mask);
   end
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      {hsel, haddr, htrans, hwrite, hprot, hwdata} = '0;
      reset_n = 1'b0;
      clockEnable = 1'b1;
      cyc = 0;
      nErrors = 0;
      checked = 0;
      rnd = 32'h8369018b;
      repeat (12) @(posedge clock);
      reset_n <= 1'b1;
      rd(A_RELOAD, 32'h0, ALL);
      rd(A_COUNT, 32'h00f00000, 32'hfff00000);
      rd(A_STATUS, 32'h0, ALL);
      level_at(lastEdge + 1, 1'b0, 1'b0);
      level_at(lastEdge + 1, 1'b1, 1'b0);
      done("reset");
      for (int i = 0; i < 4; i++) begin
         v = rnd;
         wr(A_COUNT, {v[31:20], 4'hf, v[15:0]});
         wr(A_COUNT, 32'h0, 1'b0);
         rd(A_COUNT, {8'h0, v[23:20], 20'h0}, 32'hfff00000);
         v = rnd;
         wr(A_RELOAD, {v[31:27], 2'b11, v[24:0]});
         rd(A_RELOAD, {7'h0, v[24:0]}, ALL);
         wr(A_RELOAD, 32'h0, 1'b0);
         rd(A_RELOAD, {7'h0, v[24:0]}, ALL);
         rd(A_RELOAD, 32'h0, ALL, 1'b0);
      end
      rd(32'h3c, 32'h0, ALL);
      rd(32'h40, 32'h0, ALL);
      done("registers");
      wr(A_COUNT, 32'd5);
      e0 = lastEdge;
      wr(A_RELOAD, 32'h0100001e);
      level_at(e0 + 6, 1'b0, 1'b0);
      level_at(e0 + 7, 1'b0, 1'b1);
      level_at(e0 + 40, 1'b0, 1'b1);
      rd(A_RELOAD, 32'h0700001e, ALL);
      rd(A_STATUS, 32'h3, ALL);
      wr(A_RELOAD, 32'h01ffffff);
      level_at(lastEdge + 2, 1'b0, 1'b0);
      level_at(e0 + 69, 1'b0, 1'b1);
      rd(A_RELOAD, 32'h03ffffff, ALL);
      rd(A_COUNT, 32'h00f00000, 32'hfff00000);
      done("expiry");
      wr(A_CTRL, 32'h1);
      level_at(lastEdge + 2, 1'b0, 1'b0);
      wr(A_CTRL, 32'h2);
      level_at(lastEdge + 2, 1'b0, 1'b0);
      wr(A_CTRL, 32'h0);
      level_at(lastEdge + 2, 1'b0, 1'b1);
      wr(A_RELOAD, 32'h02ffffff);
      level_at(lastEdge + 2, 1'b0, 1'b0);
      rd(A_RELOAD, 32'h02ffffff, ALL);
      done("block");
      level_at(lastEdge + 1, 1'b1, 1'b0);
      wr(A_MASK, 32'h2);
      level_at(lastEdge + 2, 1'b1, 1'b1);
      wr(A_STATUS, 32'h2);
      level_at(lastEdge + 2, 1'b1, 1'b0);
      wr(A_MASK, 32'h1);
      level_at(lastEdge + 2, 1'b1, 1'b1);
      wr(A_STATUS, 32'h1);
      level_at(lastEdge + 2, 1'b1, 1'b0);
      rd(A_STATUS, 32'h0, ALL);
      done("interrupt");
      wr(A_RELOAD, 32'h00ffffff);
      wr(A_COUNT, 32'd3);
      e0 = lastEdge;
      level_at(e0 + 5, 1'b1, 1'b1);
      level_at(e0 + 6, 1'b0, 1'b0);
      rd(A_RELOAD, 32'h02ffffff, ALL);
      done("disabled expiry");
      wr(A_COUNT, 32'h00000100);
      @(posedge clock);
      clockEnable <= 1'b0;
      repeat (10) @(posedge clock);
      clockEnable <= 1'b1;
      rd(A_COUNT, 32'h000000fd, ALL);
      done("freeze");
      repeat (2) @(posedge clock);
      reportAndStop();
   end
endmodule
